// ==== verilog/stpc_ctrl.sv ====
/*
 * Sensor-scanner timing and peripheral control: holds the timing, peripheral
 * and decoder control registers and turns them into clock-enable ticks for the
 * period counter and both timers, comparator/DAC control and decoder inputs.
 * Assumes the slow peripheral clock and the auxiliary fast oscillator arrive as
 * one-cycle tick pulses synchronous to i_core_clk, and that the scan sequencer
 * outside supplies idle, scan-start and channel-start strobes and the interaction threshold.
 */
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
module stpc_ctrl (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Register port
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Source clock ticks
    input wire logic i_slow_tick,
    input wire logic i_slow_half_tick,
    input wire logic i_fast_tick,
    // Scan sequencer status
    input wire logic i_scanner_idle,
    input wire logic i_scan_start,
    input wire logic i_channel_start,
    input wire logic [11:0] i_interaction_threshold,
    input wire logic [11:0] i_conv0_value,
    input wire logic [11:0] i_conv1_value,
    // Comparators
    input wire logic [1:0] i_cmp_raw,
    output logic [1:0] o_cmp_out,
    output logic [1:0] o_cmp_powered,
    output logic [1:0] o_cmp_mux_ctrl,
    output logic [1:0] o_cmp_level_ctrl,
    // Voltage DAC
    output logic o_dac_powered,
    output logic o_dac_start,
    output logic [1:0] o_dac_takeover,
    output logic [11:0] o_conv0_data,
    output logic [11:0] o_conv1_data,
    // Timer ticks
    output logic o_pc_tick,
    output logic o_slow_timer_tick,
    output logic o_fast_timer_tick,
    // Event channels to decoder
    input wire logic [11:0] i_event_ch,
    output logic [1:0] o_dec_hi_bits
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Prescaler tick: fires when the low code bits of the count are all ones
    function automatic logic stpc_div_hit(input logic [6:0] cnt, input logic [2:0] code);
        logic [6:0] msk;
        msk = 7'(({7'h00, 1'b1} << code) - 8'h01);
        return (cnt & msk) == msk;
    endfunction : stpc_div_hit

    // Event channel pick; codes above the last channel read zero
    function automatic logic stpc_ev_pick(input logic [11:0] ev, input logic [3:0] sel);
        return (sel <= stpc_pkg::STPC_EVENT_CH_MAX) ? ev[sel] : 1'b0;
    endfunction : stpc_ev_pick

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [31:0] timing_r, timing_nxt;   // timing_control
    logic [31:0] periph_r, periph_nxt;   // peripheral_control
    logic [31:0] decode_r, decode_nxt;   // decoder_control
    logic [31:0] rdata_r, rdata_nxt;     // Read data, one cycle after strobe

    // Write side; reserved bits are kept at zero regardless of what is written,
    // so a careless write cannot reach hidden state
    always_comb begin
        timing_nxt = timing_r;
        periph_nxt = periph_r;
        decode_nxt = decode_r;
        rdata_nxt = 32'h0000_0000;
        if (i_wr) begin
            unique case (i_addr)
                stpc_pkg::STPC_OFS_TIMING: timing_nxt = i_wdata & stpc_pkg::STPC_TIMING_MASK;
                stpc_pkg::STPC_OFS_PERIPH: periph_nxt = i_wdata & stpc_pkg::STPC_PERIPH_MASK;
                stpc_pkg::STPC_OFS_DECODE: decode_nxt = i_wdata & stpc_pkg::STPC_DECODE_MASK;
                default: ; // Unmapped writes are dropped
            endcase
        end
        if (i_rd) begin
            unique case (i_addr)
                stpc_pkg::STPC_OFS_TIMING: rdata_nxt = timing_r;
                stpc_pkg::STPC_OFS_PERIPH: rdata_nxt = periph_r;
                stpc_pkg::STPC_OFS_DECODE: rdata_nxt = decode_r;
                default: rdata_nxt = 32'h0000_0000; // Unmapped reads as zero
            endcase
        end
    end

    // Register bank, synchronous reset to documented values
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            timing_r <= stpc_pkg::STPC_TIMING_RST;
            periph_r <= stpc_pkg::STPC_PERIPH_RST;
            decode_r <= stpc_pkg::STPC_DECODE_RST;
            rdata_r <= 32'h0000_0000;
        end else begin
            timing_r <= timing_nxt;
            periph_r <= periph_nxt;
            decode_r <= decode_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign o_rdata = rdata_r;

    // ------------------------------------------------------------------
    // Field views
    // ------------------------------------------------------------------
    logic [1:0] fast_timer_divider;
    logic [2:0] slow_timer_divider;
    logic [2:0] period_counter_divider;
    logic [1:0] idle_power_policy;
    logic [1:0] comparator0_control_mode;
    logic [1:0] comparator1_control_mode;
    logic [3:0] decoder_bit2_source;
    logic [3:0] decoder_bit3_source;

    assign fast_timer_divider = timing_r[stpc_pkg::STPC_FAST_DIV_LSB +: 2];
    assign slow_timer_divider = timing_r[stpc_pkg::STPC_SLOW_DIV_LSB +: 3];
    assign period_counter_divider = timing_r[stpc_pkg::STPC_PC_DIV_LSB +: 3];
    assign idle_power_policy = periph_r[stpc_pkg::STPC_IDLE_PWR_LSB +: 2];
    assign comparator0_control_mode = periph_r[stpc_pkg::STPC_CMP0_MODE_LSB +: 2];
    assign comparator1_control_mode = periph_r[stpc_pkg::STPC_CMP1_MODE_LSB +: 2];
    assign decoder_bit2_source = decode_r[stpc_pkg::STPC_DEC2_SRC_LSB +: 4];
    assign decoder_bit3_source = decode_r[stpc_pkg::STPC_DEC3_SRC_LSB +: 4];

    // ------------------------------------------------------------------
    // Prescalers
    // ------------------------------------------------------------------
    // Free-running counts of source ticks; a shared count keeps divider
    // changes glitch-free at the cost of a phase that is not realigned.
    logic [6:0] slow_cnt_r, slow_cnt_nxt;   // Slow clock tick count
    logic [2:0] fast_cnt_r, fast_cnt_nxt;   // Oscillator tick count
    logic pc_tick_r, pc_tick_nxt;
    logic slow_tm_r, slow_tm_nxt;
    logic fast_tm_r, fast_tm_nxt;

    // Next counts and tick pulses
    always_comb begin
        slow_cnt_nxt = slow_cnt_r;
        fast_cnt_nxt = fast_cnt_r;
        pc_tick_nxt = 1'b0;
        slow_tm_nxt = 1'b0;
        fast_tm_nxt = 1'b0;
        if (i_slow_tick) begin
            slow_cnt_nxt = 7'(slow_cnt_r + 7'h01);
            pc_tick_nxt = stpc_div_hit(slow_cnt_r, period_counter_divider);
            slow_tm_nxt = stpc_div_hit(slow_cnt_r, slow_timer_divider);
        end
        if (i_fast_tick) begin
            fast_cnt_nxt = 3'(fast_cnt_r + 3'h1);
            fast_tm_nxt = stpc_div_hit({4'h0, fast_cnt_r}, {1'b0, fast_timer_divider});
        end
    end

    // Prescaler state
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            slow_cnt_r <= 7'h00;
            fast_cnt_r <= 3'h0;
            pc_tick_r <= 1'b0;
            slow_tm_r <= 1'b0;
            fast_tm_r <= 1'b0;
        end else begin
            slow_cnt_r <= slow_cnt_nxt;
            fast_cnt_r <= fast_cnt_nxt;
            pc_tick_r <= pc_tick_nxt;
            slow_tm_r <= slow_tm_nxt;
            fast_tm_r <= fast_tm_nxt;
        end
    end

    assign o_pc_tick = pc_tick_r;
    assign o_slow_timer_tick = slow_tm_r;
    assign o_fast_timer_tick = fast_tm_r;

    // ------------------------------------------------------------------
    // Comparator and DAC control
    // ------------------------------------------------------------------
    logic [1:0] cmp_out_r, cmp_out_nxt;
    logic [1:0] cmp_pwr_r, cmp_pwr_nxt;
    logic [1:0] cmp_mux_r, cmp_mux_nxt;
    logic [1:0] cmp_lvl_r, cmp_lvl_nxt;
    logic dac_pwr_r, dac_pwr_nxt;
    logic dac_start_r, dac_start_nxt;
    logic [1:0] take_r, take_nxt;
    logic [11:0] conv0_r, conv0_nxt;
    logic [11:0] conv1_r, conv1_nxt;
    logic dac_pend_r, dac_pend_nxt;   // Trigger seen, waiting for lead edge
    logic [1:0] cmp_mode [2];

    assign cmp_mode[0] = comparator0_control_mode;
    assign cmp_mode[1] = comparator1_control_mode;

    // Next comparator/DAC outputs
    always_comb begin
        logic trig;
        logic lead_edge;
        trig = 1'b0;
        lead_edge = 1'b0;
        // Comparator results, optionally inverted
        cmp_out_nxt[0] = i_cmp_raw[0] ^ periph_r[stpc_pkg::STPC_CMP0_INV_BIT];
        cmp_out_nxt[1] = i_cmp_raw[1] ^ periph_r[stpc_pkg::STPC_CMP1_INV_BIT];
        // Mode decides which comparator controls the scanner drives
        for (int k = 0; k < 2; k++) begin
            cmp_mux_nxt[k] = (cmp_mode[k] == stpc_pkg::STPC_CMP_MUX) ||
                             (cmp_mode[k] == stpc_pkg::STPC_CMP_MUXTHR);
            cmp_lvl_nxt[k] = (cmp_mode[k] == stpc_pkg::STPC_CMP_MUXTHR);
        end
        // Idle power: busy keeps all on; idle obeys the policy bits
        cmp_pwr_nxt = (!i_scanner_idle || idle_power_policy[0]) ? 2'h3 : 2'h0;
        dac_pwr_nxt = !i_scanner_idle || idle_power_policy[1];
        // Takeover of each DAC channel
        take_nxt[0] = periph_r[stpc_pkg::STPC_CONV0_TAKE_BIT];
        take_nxt[1] = periph_r[stpc_pkg::STPC_CONV1_TAKE_BIT];
        // Conversion data sources
        conv0_nxt = periph_r[stpc_pkg::STPC_CONV0_SRC_BIT] ?
                    i_interaction_threshold : i_conv0_value;
        conv1_nxt = periph_r[stpc_pkg::STPC_CONV1_SRC_BIT] ?
                    i_interaction_threshold : i_conv1_value;
        // Trigger per channel or once per scan
        trig = periph_r[stpc_pkg::STPC_TRIG_BIT] ? i_scan_start : i_channel_start;
        // Lead: full slow cycle waits on full tick, half on half tick
        lead_edge = periph_r[stpc_pkg::STPC_LEAD_BIT] ? i_slow_half_tick : i_slow_tick;
        dac_pend_nxt = dac_pend_r;
        dac_start_nxt = 1'b0;
        if (trig && (take_r != 2'h0)) begin
            dac_pend_nxt = 1'b1;
        end else if (dac_pend_r && lead_edge) begin
            dac_pend_nxt = 1'b0;
            dac_start_nxt = 1'b1;
        end
    end

    // Comparator/DAC state
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            cmp_out_r <= 2'h0;
            cmp_pwr_r <= 2'h0;
            cmp_mux_r <= 2'h0;
            cmp_lvl_r <= 2'h0;
            dac_pwr_r <= 1'b0;
            dac_start_r <= 1'b0;
            take_r <= 2'h0;
            conv0_r <= 12'h000;
            conv1_r <= 12'h000;
            dac_pend_r <= 1'b0;
        end else begin
            cmp_out_r <= cmp_out_nxt;
            cmp_pwr_r <= cmp_pwr_nxt;
            cmp_mux_r <= cmp_mux_nxt;
            cmp_lvl_r <= cmp_lvl_nxt;
            dac_pwr_r <= dac_pwr_nxt;
            dac_start_r <= dac_start_nxt;
            take_r <= take_nxt;
            conv0_r <= conv0_nxt;
            conv1_r <= conv1_nxt;
            dac_pend_r <= dac_pend_nxt;
        end
    end

    assign o_cmp_out = cmp_out_r;
    assign o_cmp_powered = cmp_pwr_r;
    assign o_cmp_mux_ctrl = cmp_mux_r;
    assign o_cmp_level_ctrl = cmp_lvl_r;
    assign o_dac_powered = dac_pwr_r;
    assign o_dac_start = dac_start_r;
    assign o_dac_takeover = take_r;
    assign o_conv0_data = conv0_r;
    assign o_conv1_data = conv1_r;

    // ------------------------------------------------------------------
    // Decoder event inputs
    // ------------------------------------------------------------------
    logic [1:0] dec_r, dec_nxt;

    // Select event channels for decoder bits 2 and 3
    always_comb begin
        dec_nxt[0] = stpc_ev_pick(i_event_ch, decoder_bit2_source);
        dec_nxt[1] = stpc_ev_pick(i_event_ch, decoder_bit3_source);
    end

    // Decoder input register
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            dec_r <= 2'h0;
        end else begin
            dec_r <= dec_nxt;
        end
    end

    assign o_dec_hi_bits = dec_r;

endmodule : stpc_ctrl

// ==== verilog/stpc_pkg.sv ====
/*
 * Constants shared by the sensor-scanner timing and peripheral control block:
 * register offsets, field positions, reset values and mode encodings.
 * Assumes a word-addressed plain register port with byte offsets.
 */
package stpc_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] STPC_OFS_TIMING = 12'h004; // timing_control
    localparam logic [11:0] STPC_OFS_PERIPH = 12'h008; // peripheral_control
    localparam logic [11:0] STPC_OFS_DECODE = 12'h00C; // decoder_control

    // ------------------------------------------------------------------
    // Timing control fields
    // ------------------------------------------------------------------
    localparam int STPC_FAST_DIV_LSB = 0;   // fast_timer_divider [1:0]
    localparam int STPC_SLOW_DIV_LSB = 4;   // slow_timer_divider [6:4]
    localparam int STPC_PC_DIV_LSB = 8;     // period_counter_divider [10:8]
    localparam logic [31:0] STPC_TIMING_MASK = 32'h0000_0773;
    localparam logic [31:0] STPC_TIMING_RST = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Peripheral control fields
    // ------------------------------------------------------------------
    localparam int STPC_CONV0_TAKE_BIT = 0;
    localparam int STPC_CONV1_TAKE_BIT = 1;
    localparam int STPC_CONV0_SRC_BIT = 2;
    localparam int STPC_CONV1_SRC_BIT = 3;
    localparam int STPC_LEAD_BIT = 6;
    localparam int STPC_TRIG_BIT = 8;
    localparam int STPC_CMP0_MODE_LSB = 20;
    localparam int STPC_CMP1_MODE_LSB = 22;
    localparam int STPC_CMP0_INV_BIT = 24;
    localparam int STPC_CMP1_INV_BIT = 25;
    localparam int STPC_IDLE_PWR_LSB = 28;
    localparam logic [31:0] STPC_PERIPH_MASK = 32'h3FF0_014F;
    localparam logic [31:0] STPC_PERIPH_RST = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Decoder control fields
    // ------------------------------------------------------------------
    localparam int STPC_DEC2_SRC_LSB = 20;
    localparam int STPC_DEC3_SRC_LSB = 25;
    localparam logic [31:0] STPC_DECODE_MASK = 32'h1EF0_0000;
    localparam logic [31:0] STPC_DECODE_RST = 32'h0000_0000;
    localparam logic [3:0] STPC_EVENT_CH_MAX = 4'hB; // highest event channel

    // ------------------------------------------------------------------
    // Comparator control modes
    // ------------------------------------------------------------------
    localparam logic [1:0] STPC_CMP_NONE = 2'h0;
    localparam logic [1:0] STPC_CMP_MUX = 2'h1;
    localparam logic [1:0] STPC_CMP_MUXTHR = 2'h2;

endpackage : stpc_pkg

// ==== verif/stpc_ctrl_asserts.sv ====
/*
 * Checker for the sensor-scanner control block: shadow registers built from
 * the register port, and timing relations between inputs and outputs.
 * Assumes it is bound into stpc_ctrl and sees only that module's ports.
 */
`timescale 1ns/1ns
module stpc_ctrl_chk (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Register port
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    // Ticks, scanner and data inputs
    input wire logic i_slow_tick,
    input wire logic i_slow_half_tick,
    input wire logic i_fast_tick,
    input wire logic i_scanner_idle,
    input wire logic [11:0] i_interaction_threshold,
    input wire logic [11:0] i_conv0_value,
    input wire logic [11:0] i_conv1_value,
    input wire logic [11:0] i_event_ch,
    input wire logic [1:0] i_cmp_raw,
    // Observed outputs
    input wire logic [1:0] o_cmp_out,
    input wire logic [1:0] o_cmp_powered,
    input wire logic [1:0] o_cmp_mux_ctrl,
    input wire logic [1:0] o_cmp_level_ctrl,
    input wire logic o_dac_powered,
    input wire logic o_dac_start,
    input wire logic [1:0] o_dac_takeover,
    input wire logic [11:0] o_conv0_data,
    input wire logic [11:0] o_conv1_data,
    input wire logic o_pc_tick,
    input wire logic o_slow_timer_tick,
    input wire logic o_fast_timer_tick,
    input wire logic [1:0] o_dec_hi_bits
);
    // ------------------------------------------------------------------
    // Shadow registers
    // ------------------------------------------------------------------
    logic [31:0] tim_r, per_r, dec_r; // Mirrors of the three registers
    logic [31:0] rd_exp; // Read data due for the current address
    logic [3:0] ctl_exp; // Expected {mux, level} controls
    logic [2:0] pwr_exp; // Expected {cmp1, cmp0, dac} power
    logic [1:0] dec_exp; // Expected decoder bits
    logic [23:0] conv_exp; // Expected {conv1, conv0} data
    logic lead_tick; // Tick that the lead bit picks
    // Masked like the design so reserved bits mirror as zero
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            tim_r <= 32'h0;
            per_r <= 32'h0;
            dec_r <= 32'h0;
        end else if (i_wr) begin
            if (i_addr == stpc_pkg::STPC_OFS_TIMING) tim_r <= i_wdata & stpc_pkg::STPC_TIMING_MASK;
            if (i_addr == stpc_pkg::STPC_OFS_PERIPH) per_r <= i_wdata & stpc_pkg::STPC_PERIPH_MASK;
            if (i_addr == stpc_pkg::STPC_OFS_DECODE) dec_r <= i_wdata & stpc_pkg::STPC_DECODE_MASK;
        end
    end
    // Expected values; channel codes above 11 select nothing
    always_comb begin
        case (i_addr)
            stpc_pkg::STPC_OFS_TIMING: rd_exp = tim_r;
            stpc_pkg::STPC_OFS_PERIPH: rd_exp = per_r;
            stpc_pkg::STPC_OFS_DECODE: rd_exp = dec_r;
            default: rd_exp = 32'h0;
        endcase
        ctl_exp = {per_r[23:22] == 2'h1 || per_r[23:22] == 2'h2,
                   per_r[21:20] == 2'h1 || per_r[21:20] == 2'h2,
                   per_r[23:22] == 2'h2, per_r[21:20] == 2'h2};
        pwr_exp = i_scanner_idle ? {per_r[28], per_r[28], per_r[29]} : 3'h7;
        dec_exp[0] = (dec_r[23:20] <= 4'hB) ? i_event_ch[dec_r[23:20]] : 1'h0;
        dec_exp[1] = (dec_r[28:25] <= 4'hB) ? i_event_ch[dec_r[28:25]] : 1'h0;
        conv_exp[11:0] = per_r[2] ? i_interaction_threshold : i_conv0_value;
        conv_exp[23:12] = per_r[3] ? i_interaction_threshold : i_conv1_value;
        lead_tick = per_r[6] ? i_slow_half_tick : i_slow_tick;
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    a_read_data: assert property (i_rd |=> o_rdata == $past(rd_exp))
        else $error("read data differs from written value");
    a_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0)
        else $error("read data not zero outside a read");
    a_cmp_invert: assert property (i_nrst |=> o_cmp_out == ($past(i_cmp_raw) ^ $past(per_r[25:24])))
        else $error("comparator output inversion wrong");
    a_cmp_modes: assert property (i_nrst |=> {o_cmp_mux_ctrl, o_cmp_level_ctrl} == $past(ctl_exp))
        else $error("comparator control mode wrong");
    a_idle_power: assert property (i_nrst |=> {o_cmp_powered, o_dac_powered} == $past(pwr_exp))
        else $error("power level wrong");
    a_takeover_bits: assert property (i_nrst |=> o_dac_takeover == $past(per_r[1:0]))
        else $error("takeover bits wrong");
    a_conv_source: assert property (i_nrst |=> {o_conv1_data, o_conv0_data} == $past(conv_exp))
        else $error("conversion data source wrong");
    a_decoder_src: assert property (i_nrst |=> o_dec_hi_bits == $past(dec_exp))
        else $error("decoder source wrong");
    a_slow_source: assert property ((o_pc_tick || o_slow_timer_tick) |-> $past(i_slow_tick))
        else $error("slow divider tick without slow clock");
    a_fast_source: assert property (o_fast_timer_tick |-> $past(i_fast_tick))
        else $error("fast divider tick without oscillator");
    a_dac_lead: assert property (o_dac_start |-> $past(lead_tick) ##1 !o_dac_start)
        else $error("converter start at wrong lead");
    c_dac_start: cover property (o_dac_start);
    c_pc_tick: cover property (o_pc_tick);
    c_idle_on: cover property (i_scanner_idle && o_dac_powered);
endmodule : stpc_ctrl_chk

bind stpc_ctrl stpc_ctrl_chk u_chk (.*);

// ==== verif/stpc_analog_model.sv ====
/*
 * Behavioural model of the two analog comparators facing the control block.
 * Assumes it is clocked by the core clock and powered by the block.
 */
`timescale 1ns/1ns
module stpc_analog_model (
    // Clock
    input wire logic i_core_clk,
    // Power from the control block
    input wire logic [1:0] i_cmp_powered,
    // Raw comparator decisions
    output logic [1:0] o_cmp_raw
);
    // ------------------------------------------------------------------
    // Decision pattern
    // ------------------------------------------------------------------
    logic [3:0] cnt_r = 4'h0; // Sweep that makes decisions change often
    // An unpowered comparator cannot decide, so its output rests low
    always_ff @(posedge i_core_clk) begin
        cnt_r <= cnt_r + 4'h1;
        o_cmp_raw <= (cnt_r[1:0] ^ cnt_r[3:2]) & i_cmp_powered;
    end
endmodule : stpc_analog_model

// ==== verif/stpc_ctrl_tb.sv ====
/*
 * Self-checking bench for the sensor-scanner control block: registers,
 * dividers, comparator and converter control, decoder sources.
 * Assumes the comparator model and the bound checker sit beside the block.
 */
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin \
    miscompares++; $display("[FAIL] %0t %s", $time, msg); end end
module stpc_ctrl_tb;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic i_core_clk = 1'h0, i_nrst = 1'h0, i_wr = 1'h0, i_rd = 1'h0;
    logic [11:0] i_addr = 12'h0;
    logic [31:0] i_wdata = 32'h0, o_rdata;
    logic i_slow_tick = 1'h0, i_slow_half_tick = 1'h0, i_fast_tick = 1'h0;
    logic i_scanner_idle = 1'h0, i_scan_start = 1'h0, i_channel_start = 1'h0;
    logic [11:0] i_interaction_threshold = 12'hABC, i_conv0_value = 12'h123;
    logic [11:0] i_conv1_value = 12'h456, i_event_ch = 12'hA5C;
    logic [11:0] o_conv0_data, o_conv1_data;
    logic [1:0] i_cmp_raw, o_cmp_out, o_cmp_powered, o_cmp_mux_ctrl, o_cmp_level_ctrl;
    logic [1:0] o_dac_takeover, o_dec_hi_bits, raw_q, cm0, cm1;
    logic o_dac_powered, o_dac_start, o_pc_tick, o_slow_timer_tick, o_fast_timer_tick;
    int cyc = 0, miscompares = 0, total_checks = 0, n_pc = 0, n_sl = 0, n_fa = 0, n_dac = 0;
    int s_pc, s_sl, s_fa, s_dac;

    stpc_ctrl dut (.*);
    stpc_analog_model u_model (.i_core_clk(i_core_clk), .i_cmp_powered(o_cmp_powered),
                               .o_cmp_raw(i_cmp_raw));

    // ------------------------------------------------------------------
    // Clock, ticks and counters
    // ------------------------------------------------------------------
    initial forever #2 i_core_clk = ~i_core_clk;
    // Slow clock every 4 cycles with its half mark, oscillator every 2
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        i_slow_tick <= (cyc % 4 == 0);
        i_slow_half_tick <= (cyc % 4 == 2);
        i_fast_tick <= cyc[0];
        raw_q <= i_cmp_raw;
        n_pc <= n_pc + int'(o_pc_tick);
        n_sl <= n_sl + int'(o_slow_timer_tick);
        n_fa <= n_fa + int'(o_fast_timer_tick);
        n_dac <= n_dac + int'(o_dac_start);
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'h1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'h0;
    endtask : wr
    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge i_core_clk);
        i_rd <= 1'h1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'h0;
        #1;
        `CHK(o_rdata, e, "read data")
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask : settle
    // Counter snapshots keep one writer per counter
    task automatic snap();
        s_pc = n_pc;
        s_sl = n_sl;
        s_fa = n_fa;
        s_dac = n_dac;
    endtask : snap
    task automatic pulse(input logic scan);
        snap();
        @(posedge i_core_clk);
        i_scan_start <= scan;
        i_channel_start <= !scan;
        @(posedge i_core_clk);
        i_scan_start <= 1'h0;
        i_channel_start <= 1'h0;
        settle(12);
    endtask : pulse
    function automatic logic dbit(input int c);
        return (c < 12) ? i_event_ch[c] : 1'h0;
    endfunction : dbit
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        #50000;
        miscompares++;
        close_out();
    end
    initial begin
        repeat (4) @(posedge i_core_clk);
        i_nrst <= 1'h1;
        rd(stpc_pkg::STPC_OFS_TIMING, 32'h0);
        rd(stpc_pkg::STPC_OFS_DECODE, 32'h0);
        rd(stpc_pkg::STPC_OFS_PERIPH, 32'h0);
        wr(stpc_pkg::STPC_OFS_TIMING, stpc_pkg::STPC_TIMING_MASK);
        rd(stpc_pkg::STPC_OFS_TIMING, stpc_pkg::STPC_TIMING_MASK);
        wr(stpc_pkg::STPC_OFS_PERIPH, stpc_pkg::STPC_PERIPH_MASK);
        rd(stpc_pkg::STPC_OFS_PERIPH, stpc_pkg::STPC_PERIPH_MASK);
        wr(stpc_pkg::STPC_OFS_DECODE, stpc_pkg::STPC_DECODE_MASK);
        rd(stpc_pkg::STPC_OFS_DECODE, stpc_pkg::STPC_DECODE_MASK);
        wr(12'h010, 32'hFFFF_FFFF);
        rd(12'h010, 32'h0);
        $display("test registers done");
        // Each window spans 256 slow ticks and 512 oscillator ticks
        for (int k = 0; k < 8; k++) begin
            wr(stpc_pkg::STPC_OFS_TIMING, {21'h0, 3'(6 + k % 2), 1'h0, 3'(k), 2'h0, 2'(k % 4)});
            settle(4);
            snap();
            settle(1024);
            `CHK(n_pc - s_pc, 256 >> (6 + k % 2), "period divider")
            `CHK(n_sl - s_sl, 256 >> k, "slow divider")
            `CHK(n_fa - s_fa, 512 >> (k % 4), "fast divider")
        end
        $display("test dividers done");
        for (int m = 0; m < 4; m++) begin
            cm1 = 2'(m % 3);
            cm0 = 2'h2 - cm1;
            wr(stpc_pkg::STPC_OFS_PERIPH, {2'h0, 2'(m), 2'h0, 2'(m), cm1, cm0, 11'h0,
                                           1'(m), 1'h0, 1'(m >> 1), 2'h0, 2'(m), 2'(m)});
            settle(3);
            `CHK(o_cmp_mux_ctrl, {cm1 != 2'h0, cm0 != 2'h0}, "mux control")
            `CHK(o_cmp_level_ctrl, {cm1 == 2'h2, cm0 == 2'h2}, "level control")
            `CHK(o_cmp_out, raw_q ^ 2'(m), "comparator invert")
            `CHK(o_dac_takeover, 2'(m), "takeover")
            `CHK(o_conv0_data, m % 2 ? 12'hABC : 12'h123, "conv0 data")
            `CHK(o_conv1_data, m > 1 ? 12'hABC : 12'h456, "conv1 data")
            `CHK({o_cmp_powered, o_dac_powered}, 3'h7, "busy power")
            @(posedge i_core_clk) i_scanner_idle <= 1'h1;
            settle(3);
            `CHK({o_cmp_powered, o_dac_powered}, {{2{m % 2 == 1}}, m > 1}, "idle power")
            @(posedge i_core_clk) i_scanner_idle <= 1'h0;
            pulse(1'h0);
            `CHK(n_dac - s_dac, int'(m == 2), "start per channel")
            pulse(1'h1);
            `CHK(n_dac - s_dac, int'(m % 2 == 1), "start per scan")
        end
        $display("test analog control done");
        for (int c = 0; c < 16; c++) begin
            wr(stpc_pkg::STPC_OFS_DECODE, {3'h0, 4'(c), 1'h0, 4'(15 - c), 20'h0});
            settle(3);
            `CHK(o_dec_hi_bits, {dbit(c), dbit(15 - c)}, "decoder sources")
        end
        $display("test decoder done");
        close_out();
    end
endmodule : stpc_ctrl_tb
